//--- core/mco_map.vh
// constants for the microcontroller clock output block
// assumes inclusion by bare name from core design files
`ifndef MCO_MAP_VH
`define MCO_MAP_VH

// ****************************************
// register map
// ****************************************
`define MCO_ADDR_W        7
`define MCO_CTL_OFFSET    7'h0a
`define MCO_CTL_RESET     8'h0b
`define MCO_SEL_LSB       0
`define MCO_SEL_MSB       2
`define MCO_ENLFC_BIT     3
`define MCO_TAIL_LSB      4
`define MCO_TAIL_MSB      5
`define MCO_SEL_LF        3'h7

// ****************************************
// output period in crystal half cycles
// ****************************************
`define MCO_PER_30M       7'h02
`define MCO_PER_15M       7'h04
`define MCO_PER_10M       7'h06
`define MCO_PER_4M        7'h0f
`define MCO_PER_3M        7'h14
`define MCO_PER_2M        7'h1e
`define MCO_PER_1M        7'h3c

// ****************************************
// clock tail lengths in output cycles
// ****************************************
`define MCO_TAIL_0        10'h000
`define MCO_TAIL_1        10'h080
`define MCO_TAIL_2        10'h100
`define MCO_TAIL_3        10'h200

// ****************************************
// timing
// ****************************************
`define MCLK_PERIOD_NS    8
`define SWRST_MIN_US      50
`define SWRST_MAX_US      470
`define SWRST_MIN_CYC     ((`SWRST_MIN_US * 1000 + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define SWRST_MAX_CYC     ((`SWRST_MAX_US * 1000) / `MCLK_PERIOD_NS)

`endif

//--- core/soft_reset_pulse.v
// stretches a software reset request into a fixed internal reset pulse
// assumes start is a pulse from logic on mclk
module soft_reset_pulse #(
   parameter PULSE_CYCLES = 6250,
   parameter CNT_W        = 13
) (
   input  wire             mclk,
   input  wire             nrst,
   input  wire             start,
   output reg              active
);

   reg [CNT_W-1:0] cnt_r;

   // ****************************************
   // pulse counter
   // ****************************************
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_r  <= {CNT_W{1'b0}};
         active <= 1'b0;
      end else if (start) begin
         cnt_r  <= PULSE_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
         active <= 1'b1;
      end else if (active) begin
         if (cnt_r == {CNT_W{1'b0}}) begin
            active <= 1'b0;
         end else begin
            cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // soft_reset_pulse

//--- core/xtal_divider.v
// integer divider counting both edges of the synchronised crystal level
// assumes xtal_s already passed two flip-flops on mclk
module xtal_divider #(
   parameter PER_W = 7
) (
   input  wire             mclk,
   input  wire             nrst,
   input  wire             xtal_s,
   input  wire             restart,
   input  wire [PER_W-1:0] period,
   output reg              div_out
);

   reg  [PER_W-1:0] cnt_r;
   reg              prev_r;
   wire             edge_ev;
   wire [PER_W-1:0] low_len;
   wire [PER_W-1:0] cnt_nxt;

   assign edge_ev = xtal_s ^ prev_r;
   assign low_len = period - (period >> 1);
   assign cnt_nxt = (cnt_r >= period - {{(PER_W-1){1'b0}}, 1'b1}) ? {PER_W{1'b0}} :
                    cnt_r + {{(PER_W-1){1'b0}}, 1'b1};

   // ****************************************
   // half-cycle counter, low phase first
   // ****************************************
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_r   <= {PER_W{1'b0}};
         prev_r  <= 1'b0;
         div_out <= 1'b0;
      end else begin
         prev_r <= xtal_s;
         if (restart) begin
            cnt_r   <= {PER_W{1'b0}};
            div_out <= 1'b0;
         end else if (edge_ev) begin
            cnt_r   <= cnt_nxt;
            div_out <= (cnt_nxt >= low_len);
         end
      end
   end

endmodule // xtal_divider

//--- core/mcu_clock_output.v
// microcontroller clock output: divider select, low-frequency fallback,
// clock tail, interrupt hold and software reset pulse
// assumes xtal_clk, rc_clk and ext32_clk are slow enough to sample on mclk;
// sleep_cmd, irq_pending and register strobes come from logic on mclk
//
// Summary of operation
// - three-bit select picks 30,15,10,4,3,2,1 MHz or 32.768 kHz.
// - all non-low-frequency outputs come from integer division of the crystal.
// - low-frequency output comes from RC or external 32 kHz source as selected.
// - after reset the second pin carries the microcontroller clock.
// - in idle, transmit or receive the selected frequency is output.
// - the crystal oscillator is stopped in sleep.
// - fallback enabled and asleep gives 32.768 kHz regardless of select.
// - fallback disabled stops the output clock in sleep.
// - before stopping, emit 0, 128, 256 or 512 extra cycles.
// - a pending interrupt keeps clock and crystal running.
// - once the interrupt clears, the commanded mode and its gating apply.
// - any reset returns the control register to its default.
// - software reset holds the internal reset for 50 to 470 us.
`include "mco_map.vh"

module mcu_clock_output #(
   parameter SWRST_CYCLES = `SWRST_MIN_CYC,
   parameter SWRST_W      = 13,
   parameter PER_W        = 7,
   parameter TAIL_W       = 10
) (
   input  wire                    mclk,
   input  wire                    nrst,
   input  wire [`MCO_ADDR_W-1:0]  reg_addr,
   input  wire [7:0]              reg_wdata,
   input  wire                    reg_wr,
   input  wire                    reg_rd,
   output reg  [7:0]              reg_rdata,
   input  wire                    soft_reset_req,
   input  wire                    sleep_cmd,
   input  wire                    irq_pending,
   input  wire                    lf_ext_sel,
   input  wire                    xtal_clk,
   input  wire                    rc_clk,
   input  wire                    ext32_clk,
   output reg                     gp_pin_two,
   output reg                     xtal_en,
   output wire                    int_reset_n,
   output reg                     clk_stopped,
   output reg                     clk_on_lf
);

   // ****************************************
   // declarations
   // ****************************************
   localparam ST_RUN   = 2'b00;
   localparam ST_DRAIN = 2'b01;
   localparam ST_TAIL  = 2'b10;
   localparam ST_OFF   = 2'b11;
   localparam [7:0] CTL_RST = `MCO_CTL_RESET;

   reg  [2:0]        s1_r;
   reg  [2:0]        s2_r;
   reg  [5:0]        ctl_r;
   reg  [1:0]        state_r;
   reg  [1:0]        state_nxt;
   reg               src_lf_r;
   reg  [2:0]        cur_sel_r;
   reg               arm_r;
   reg               src_d_r;
   reg  [TAIL_W-1:0] tail_r;
   reg  [TAIL_W-1:0] tail_nxt;
   reg               do_switch;
   wire [2:0]        async_in;
   wire              srst;
   wire              xtal_s;
   wire              lf_s;
   wire              div_out;
   wire [2:0]        sel;
   wire              enlfc;
   wire [1:0]        clkt;
   wire              eff_sleep;
   wire              want_off;
   wire              want_lf;
   wire              need_switch;
   wire              src;
   wire              rise;
   wire              arm_nxt;
   wire              out_nxt;
   wire              fall_ev;
   wire              ctl_hit;

   // ****************************************
   // decode functions
   // ****************************************
   function [PER_W-1:0] period_of;
      input [2:0] s;
      begin
         case (s)
            3'h0:    period_of = `MCO_PER_30M;
            3'h1:    period_of = `MCO_PER_15M;
            3'h2:    period_of = `MCO_PER_10M;
            3'h3:    period_of = `MCO_PER_4M;
            3'h4:    period_of = `MCO_PER_3M;
            3'h5:    period_of = `MCO_PER_2M;
            default: period_of = `MCO_PER_1M;
         endcase
      end
   endfunction

   function [TAIL_W-1:0] tail_of;
      input [1:0] t;
      begin
         case (t)
            2'h1:    tail_of = `MCO_TAIL_1;
            2'h2:    tail_of = `MCO_TAIL_2;
            2'h3:    tail_of = `MCO_TAIL_3;
            default: tail_of = `MCO_TAIL_0;
         endcase
      end
   endfunction

   // ****************************************
   // input synchronisers
   // ****************************************
   assign async_in = {ext32_clk, rc_clk, xtal_clk};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
         always @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               s1_r[gi] <= 1'b0;
               s2_r[gi] <= 1'b0;
            end else begin
               s1_r[gi] <= async_in[gi];
               s2_r[gi] <= s1_r[gi];
            end
         end
      end
   endgenerate

   assign xtal_s = s2_r[0];
   assign lf_s   = lf_ext_sel ? s2_r[2] : s2_r[1];

   // ****************************************
   // software reset
   // ****************************************
   soft_reset_pulse #(
      .PULSE_CYCLES (SWRST_CYCLES),
      .CNT_W        (SWRST_W)
   ) u_soft_reset (
      .mclk   (mclk),
      .nrst   (nrst),
      .start  (soft_reset_req),
      .active (srst)
   );

   assign int_reset_n = ~srst;

   // ****************************************
   // control register
   // ****************************************
   assign ctl_hit = (reg_addr == `MCO_CTL_OFFSET);

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctl_r     <= CTL_RST[5:0];
         reg_rdata <= 8'h00;
      end else if (srst) begin
         ctl_r     <= CTL_RST[5:0];
         reg_rdata <= 8'h00;
      end else begin
         if (reg_wr && ctl_hit) begin
            ctl_r <= reg_wdata[5:0];
         end
         if (reg_rd) begin
            reg_rdata <= ctl_hit ? {2'b00, ctl_r} : 8'h00;
         end
      end
   end

   assign sel   = ctl_r[`MCO_SEL_MSB:`MCO_SEL_LSB];
   assign enlfc = ctl_r[`MCO_ENLFC_BIT];
   assign clkt  = ctl_r[`MCO_TAIL_MSB:`MCO_TAIL_LSB];

   // ****************************************
   // mode and source targets
   // ****************************************
   assign eff_sleep   = sleep_cmd & ~irq_pending;
   assign want_off    = eff_sleep & ~enlfc;
   assign want_lf     = ~want_off & ((sel == `MCO_SEL_LF) | eff_sleep);
   assign need_switch = (want_lf != src_lf_r) | (~want_lf & (sel != cur_sel_r));

   // ****************************************
   // crystal divider
   // ****************************************
   xtal_divider #(
      .PER_W (PER_W)
   ) u_divider (
      .mclk    (mclk),
      .nrst    (nrst),
      .xtal_s  (xtal_s),
      .restart (do_switch),
      .period  (period_of(cur_sel_r)),
      .div_out (div_out)
   );

   // ****************************************
   // output gating
   // ****************************************
   assign src     = src_lf_r ? lf_s : div_out;
   // arm only on a true rising edge of the new source
   assign rise    = src & ~src_d_r & ~arm_r;
   assign arm_nxt = arm_r | rise;
   assign out_nxt = (state_r != ST_OFF) & arm_nxt & src;
   assign fall_ev = gp_pin_two & ~out_nxt;

   // ****************************************
   // sequencing state machine
   // ****************************************
   always @* begin
      state_nxt = state_r;
      tail_nxt  = tail_r;
      do_switch = 1'b0;
      case (state_r)
         ST_RUN: begin
            if (want_off) begin
               if (clkt == 2'b00) begin
                  state_nxt = ST_DRAIN;
               end else begin
                  state_nxt = ST_TAIL;
                  tail_nxt  = tail_of(clkt);
               end
            end else if (need_switch) begin
               state_nxt = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            if (fall_ev || !arm_r) begin
               if (want_off) begin
                  state_nxt = ST_OFF;
               end else begin
                  state_nxt = ST_RUN;
                  do_switch = 1'b1;
               end
            end
         end
         ST_TAIL: begin
            if (!want_off) begin
               state_nxt = ST_RUN;
            end else if (fall_ev) begin
               tail_nxt = tail_r - {{(TAIL_W-1){1'b0}}, 1'b1};
               if (tail_r == {{(TAIL_W-1){1'b0}}, 1'b1}) begin
                  state_nxt = ST_DRAIN;
               end
            end
         end
         ST_OFF: begin
            if (!want_off) begin
               state_nxt = ST_RUN;
               do_switch = 1'b1;
            end
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_r    <= ST_RUN;
         tail_r     <= {TAIL_W{1'b0}};
         src_lf_r   <= 1'b0;
         cur_sel_r  <= CTL_RST[`MCO_SEL_MSB:`MCO_SEL_LSB];
         arm_r      <= 1'b0;
         src_d_r    <= 1'b1;
         gp_pin_two <= 1'b0;
      end else if (srst) begin
         state_r    <= ST_RUN;
         tail_r     <= {TAIL_W{1'b0}};
         src_lf_r   <= 1'b0;
         cur_sel_r  <= CTL_RST[`MCO_SEL_MSB:`MCO_SEL_LSB];
         arm_r      <= 1'b0;
         src_d_r    <= 1'b1;
         gp_pin_two <= 1'b0;
      end else begin
         state_r <= state_nxt;
         tail_r  <= tail_nxt;
         if (do_switch) begin
            src_lf_r   <= want_lf;
            cur_sel_r  <= sel;
            arm_r      <= 1'b0;
            src_d_r    <= 1'b1;
            gp_pin_two <= 1'b0;
         end else begin
            arm_r      <= arm_nxt;
            src_d_r    <= src;
            gp_pin_two <= out_nxt;
         end
      end
   end

   // ****************************************
   // crystal enable and status
   // ****************************************
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         xtal_en     <= 1'b1;
         clk_stopped <= 1'b0;
         clk_on_lf   <= 1'b0;
      end else begin
         xtal_en     <= ~((state_r == ST_OFF) |
                          (eff_sleep & src_lf_r & (state_r == ST_RUN)));
         clk_stopped <= (state_r == ST_OFF);
         clk_on_lf   <= src_lf_r;
      end
   end

endmodule // mcu_clock_output

//--- verif/mcu_clock_output_asserts.sv
// checker for the microcontroller clock output block
// assumes it is bound to mcu_clock_output and sees its ports only
module mco_checker #(
   parameter SWRST_CYCLES = 8
) (
   input wire       mclk,
   input wire       nrst,
   input wire       soft_reset_req,
   input wire       sleep_cmd,
   input wire       irq_pending,
   input wire       gp_pin_two,
   input wire       xtal_en,
   input wire       int_reset_n,
   input wire       clk_stopped
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // ****************
   // reset pulse counter
   // ****************
   logic [15:0] low_cnt_r;
   always @(posedge mclk or negedge nrst) begin
      if (!nrst)
         low_cnt_r <= 16'h0000;
      else if (int_reset_n)
         low_cnt_r <= 16'h0000;
      else
         low_cnt_r <= low_cnt_r + 16'h0001;
   end
   // ****************
   // properties
   // ****************
   property p_swrst_len;
      $rose(int_reset_n) |-> low_cnt_r == SWRST_CYCLES;
   endproperty
   a_swrst_len: assert property (p_swrst_len) else $error("reset pulse length");
   property p_swrst_go;
      soft_reset_req && int_reset_n |=> !int_reset_n;
   endproperty
   a_swrst_go: assert property (p_swrst_go) else $error("reset pulse missing");
   property p_irq_xtal;
      irq_pending [*3] |-> xtal_en;
   endproperty
   a_irq_xtal: assert property (p_irq_xtal) else $error("crystal off with irq");
   property p_irq_wake;
      $rose(irq_pending) |-> ##[1:8] (xtal_en && !clk_stopped);
   endproperty
   a_irq_wake: assert property (p_irq_wake) else $error("irq did not wake");
   property p_stop_off;
      $rose(clk_stopped) |-> !xtal_en && !gp_pin_two;
   endproperty
   a_stop_off: assert property (p_stop_off) else $error("stop with crystal on");
   property p_stopped_low;
      clk_stopped |-> !gp_pin_two;
   endproperty
   a_stopped_low: assert property (p_stopped_low) else $error("stopped pin high");
   property p_stop_cause;
      $rose(clk_stopped) |-> $past(sleep_cmd) || $past(sleep_cmd, 2);
   endproperty
   a_stop_cause: assert property (p_stop_cause) else $error("stop without sleep");
   property p_awake_run;
      !sleep_cmd [*4] |-> xtal_en && !clk_stopped;
   endproperty
   a_awake_run: assert property (p_awake_run) else $error("clock off when awake");
   property p_high_min;
      $rose(gp_pin_two) |=> gp_pin_two;
   endproperty
   a_high_min: assert property (p_high_min) else $error("high phase too short");
   c_stop: cover property ($rose(clk_stopped));
   c_swrst: cover property ($rose(int_reset_n));
   c_irq: cover property (irq_pending && sleep_cmd && xtal_en);
endmodule // mco_checker

bind mcu_clock_output mco_checker #(.SWRST_CYCLES(SWRST_CYCLES)) i_chk (
   .mclk(mclk), .nrst(nrst), .soft_reset_req(soft_reset_req), .sleep_cmd(sleep_cmd),
   .irq_pending(irq_pending), .gp_pin_two(gp_pin_two), .xtal_en(xtal_en),
   .int_reset_n(int_reset_n), .clk_stopped(clk_stopped));

//--- verif/mcu_clk_sink.sv
// model of the microcontroller fed by the output clock
// assumes clk_in is the clock pin; measures in simulation time
module mcu_clk_sink (
   input wire clk_in
);
   timeunit 1ns;
   timeprecision 1ns;
   longint t_last    = 0;
   int     period_ns = 0;
   int     n_fall    = 0;
   always @(posedge clk_in) begin
      period_ns = int'($time - t_last);
      t_last = $time;
   end
   always @(negedge clk_in) begin
      n_fall = n_fall + 1;
   end
endmodule // mcu_clk_sink

//--- verif/tb.sv
// testbench for the microcontroller clock output block
// assumes mco_map.vh on the include path; crystal half period 24 ns
`include "mco_map.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam SWC = 8;
   logic       mclk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, soft_reset_req = 0;
   logic       sleep_cmd = 0, irq_pending = 0, lf_ext_sel = 0;
   logic       xtal_clk = 0, rc_clk = 0, ext32_clk = 0;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] rd_v;
   wire  [7:0] reg_rdata;
   wire        gp_pin_two, xtal_en, int_reset_n, clk_stopped, clk_on_lf;
   int         n_errors = 0, comparisons = 0, i, k, f0;
   int         per [0:6] = '{2, 4, 6, 15, 20, 30, 60};
   int         tails [0:3] = '{0, 128, 256, 512};
   // ****************
   // clocks and instances
   // ****************
   always #4 mclk = ~mclk;
   always #400 rc_clk = ~rc_clk;
   always #560 ext32_clk = ~ext32_clk;
   initial begin
      #1;
      forever begin
         #24;
         xtal_clk = xtal_en ? ~xtal_clk : 1'b0;
      end
   end
   mcu_clock_output #(.SWRST_CYCLES(SWC)) i_dut (
      .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .soft_reset_req(soft_reset_req), .sleep_cmd(sleep_cmd), .irq_pending(irq_pending),
      .lf_ext_sel(lf_ext_sel), .xtal_clk(xtal_clk), .rc_clk(rc_clk), .ext32_clk(ext32_clk),
      .gp_pin_two(gp_pin_two), .xtal_en(xtal_en), .int_reset_n(int_reset_n),
      .clk_stopped(clk_stopped), .clk_on_lf(clk_on_lf));
   mcu_clk_sink i_sink (.clk_in(gp_pin_two));
   // ****************
   // shared tasks
   // ****************
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task report_and_stop;
      $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [6:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      @(negedge mclk);
      rd_v = reg_rdata;
   endtask
   task per_chk(input int exp);
      repeat (3) @(posedge gp_pin_two);
      @(negedge mclk);
      chk(i_sink.period_ns, exp);
   endtask
   task wait_stop;
      for (k = 0; k < 8000 && clk_stopped !== 1'b1; k++) @(negedge mclk);
      chk(clk_stopped, 1'b1);
   endtask
   // ****************
   // scenarios
   // ****************
   task t_defaults;
      rd(`MCO_CTL_OFFSET);
      chk(rd_v, `MCO_CTL_RESET);
      rd(7'h0b);
      chk(rd_v, 8'h00);
      per_chk(15 * 24);
   endtask
   task t_select;
      wr(`MCO_CTL_OFFSET, 8'hff);
      rd(`MCO_CTL_OFFSET);
      chk(rd_v, 8'h3f);
      for (i = 0; i < 7; i++) begin
         wr(`MCO_CTL_OFFSET, 8'(i));
         per_chk(per[i] * 24);
      end
      wr(`MCO_CTL_OFFSET, 8'h07);
      per_chk(800);
      @(posedge mclk) lf_ext_sel <= 1'b1;
      per_chk(1120);
      chk(clk_on_lf, 1'b1);
   endtask
   task t_lf_sleep;
      @(posedge mclk) lf_ext_sel <= 1'b0;
      wr(`MCO_CTL_OFFSET, 8'h08);
      per_chk(48);
      @(posedge mclk) sleep_cmd <= 1'b1;
      per_chk(800);
      chk({clk_on_lf, xtal_en}, 2'b10);
      @(posedge mclk) sleep_cmd <= 1'b0;
      per_chk(48);
   endtask
   task t_tail;
      for (i = 0; i < 4; i++) begin
         wr(`MCO_CTL_OFFSET, {2'b00, 2'(i), 4'h0});
         per_chk(48);
         @(posedge mclk) sleep_cmd <= 1'b1;
         @(posedge mclk);
         @(negedge mclk) f0 = i_sink.n_fall;
         wait_stop;
         chk(i_sink.n_fall - f0, tails[i] + 1);
         @(negedge mclk);
         chk({clk_stopped, gp_pin_two, xtal_en}, 3'b100);
         @(posedge mclk) sleep_cmd <= 1'b0;
      end
   endtask
   task t_irq;
      wr(`MCO_CTL_OFFSET, 8'h00);
      @(posedge mclk);
      irq_pending <= 1'b1;
      sleep_cmd <= 1'b1;
      repeat (200) @(posedge mclk);
      @(negedge mclk) chk({clk_stopped, xtal_en}, 2'b01);
      per_chk(48);
      @(posedge mclk) irq_pending <= 1'b0;
      wait_stop;
      chk(clk_stopped, 1'b1);
      @(posedge mclk) irq_pending <= 1'b1;
      per_chk(48);
      @(posedge mclk);
      irq_pending <= 1'b0;
      sleep_cmd <= 1'b0;
   endtask
   task t_swrst;
      wr(`MCO_CTL_OFFSET, 8'h26);
      fork
         begin
            f0 = 0;
            repeat (40) begin
               @(negedge mclk);
               if (int_reset_n === 1'b0) f0++;
            end
         end
         begin
            @(posedge mclk) soft_reset_req <= 1'b1;
            @(posedge mclk) soft_reset_req <= 1'b0;
            wr(`MCO_CTL_OFFSET, 8'h11);
         end
      join
      chk(f0, SWC);
      rd(`MCO_CTL_OFFSET);
      chk(rd_v, `MCO_CTL_RESET);
      wr(`MCO_CTL_OFFSET, 8'h26);
      @(posedge mclk) nrst <= 1'b0;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      rd(`MCO_CTL_OFFSET);
      chk(rd_v, `MCO_CTL_RESET);
   endtask
   // ****************
   // main sequence and watchdog
   // ****************
   initial begin
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      t_defaults;
      t_select;
      t_lf_sleep;
      t_tail;
      t_irq;
      t_swrst;
      report_and_stop;
   end
   initial begin
      #400000;
      n_errors++;
      report_and_stop;
   end
endmodule // tb
